// file: src/tag_mode_cfg.svh
`ifndef TAG_MODE_CFG_SVH
`define TAG_MODE_CFG_SVH
// clock and time base
`define CLK_HZ 50000000
`define TICK_MS 1
`define TICK_CYC ((`CLK_HZ / 1000) * `TICK_MS)
// mode timing in ms, wake pulse in clock cycles
`define ADV_TRIG_MS 250
`define ADV_DFLT_MS 10000
`define NOMOT_TRIG_MS 20000
`define ACC_RESTART_MS 15000
`define SAMP_TRIG_MS 2000
`define SAMP_DFLT_MS 60000
`define NOMOT_DFLT_MS 7200000
`define HOLD_PD_MS 2000
`define TRIPLE_WIN_MS 1000
`define WAKE_PULSE_CYC 16
// apb register map
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_EVT 12'h008
`define REG_WIN 12'h00c
// ctrl field positions and reset value
`define CTRL_MOT_DIS 0
`define CTRL_MEAS_DIS 1
`define CTRL_STOR_DIS 2
`define CTRL_UPD_DONE 3
`define CTRL_RESET 32'h0000_0000
`endif

// file: src/tag_mode_pkg.sv
package tag_mode_pkg;
  typedef enum logic [2:0] {
    MODE_DEFAULT = 3'b000,
    MODE_TRIGGERED = 3'b001,
    MODE_STORAGE = 3'b010,
    MODE_POWER_DOWN = 3'b011,
    MODE_UPDATE = 3'b100
  } op_mode_t;
  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
endpackage

// file: src/tag_operation_mode_controller.sv
// Notes on behaviour
// - three quick button presses switch to firmware-update mode
// - motion event or button press enters Triggered mode
// - Triggered mode advertises every 250 ms
// - Triggered mode returns to Default after 20 s without motion
// - accelerometer off on Triggered entry, back on after 15 s
// - sensors sampled every 2 s Triggered, 60 s Default
// - Default mode advertises every 10 s
// - Default moves to Storage after 2 h without motion, if enabled
// - motion-disable option: only button leaves Default for Triggered
// - measurement-disable option stops all periodic sampling
// - Storage disabled: Default stays until next trigger
// - Storage stops advertising and sensors, keeps accelerometer powered unless motion-disable is set
// - Storage powers the processor fully down, no retention
// - button or motion in Storage wakes by reset into Triggered
// - Power Down only after button held over 2 s
// - Power Down like Storage, accelerometer off, button-only wake
// - update mode hands over to updater, reset when done
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tag_mode_cfg.svh"
module tag_operation_mode_controller import tag_mode_pkg::*; #(
  parameter int unsigned TICK_CYC = `TICK_CYC,
  parameter int unsigned NOMOT_DFLT_TK = `NOMOT_DFLT_MS / `TICK_MS,
  parameter int unsigned WAKE_CYC = `WAKE_PULSE_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_button,
  input wire logic i_motion,
  input wire apb_req_t i_apb,
  output apb_rsp_t o_apb,
  output logic o_adv_pulse,
  output logic o_adv_en,
  output logic o_sample_pulse,
  output logic o_sensor_en,
  output logic o_accel_en,
  output logic o_cpu_off,
  output logic o_sys_reset,
  output logic o_update_active,
  output op_mode_t o_mode
);
  localparam int TW = 24;
  localparam logic [TW-1:0] ADV_T = TW'(`ADV_TRIG_MS / `TICK_MS);
  localparam logic [TW-1:0] ADV_D = TW'(`ADV_DFLT_MS / `TICK_MS);
  localparam logic [TW-1:0] SMP_T = TW'(`SAMP_TRIG_MS / `TICK_MS);
  localparam logic [TW-1:0] SMP_D = TW'(`SAMP_DFLT_MS / `TICK_MS);
  localparam logic [TW-1:0] NOM_T = TW'(`NOMOT_TRIG_MS / `TICK_MS);
  localparam logic [TW-1:0] NOM_D = TW'(NOMOT_DFLT_TK); // default no-motion time in ticks
  localparam logic [TW-1:0] ACC_R = TW'(`ACC_RESTART_MS / `TICK_MS);
  localparam logic [TW-1:0] HLD_PD = TW'(`HOLD_PD_MS / `TICK_MS);

  // pin synchronisers
  logic btn_s1_ff, btn_s2_ff, btn_d_ff, mot_s1_ff, mot_s2_ff, mot_d_ff;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      btn_s1_ff <= 1'b0;
      btn_s2_ff <= 1'b0;
      btn_d_ff <= 1'b0;
      mot_s1_ff <= 1'b0;
      mot_s2_ff <= 1'b0;
      mot_d_ff <= 1'b0;
    end else begin
      btn_s1_ff <= i_button;
      btn_s2_ff <= btn_s1_ff;
      btn_d_ff <= btn_s2_ff;
      mot_s1_ff <= i_motion;
      mot_s2_ff <= mot_s1_ff;
      mot_d_ff <= mot_s2_ff;
    end
  end
  logic btn_rise, btn_fall, mot_rise;
  assign btn_rise = btn_s2_ff && !btn_d_ff;
  assign btn_fall = !btn_s2_ff && btn_d_ff;
  assign mot_rise = mot_s2_ff && !mot_d_ff;

  // slow system tick
  logic [31:0] pre_ff;
  logic tick;
  assign tick = (pre_ff == TICK_CYC - 1);
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_ff <= 32'h0000_0000;
    end else begin
      pre_ff <= tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
    end
  end

  // software registers
  logic [31:0] ctrl_ff;
  logic [TW-1:0] win_ff;
  logic [7:0] mot_cnt_ff, btn_cnt_ff;
  op_mode_t mode_ff, nxt_mode;
  logic upd_done_ff;
  logic wr_acc, rd_acc, addr_ok;
  assign wr_acc = i_apb.psel && i_apb.penable && i_apb.pwrite;
  assign rd_acc = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
  always_comb begin
    addr_ok = 1'b0;
    unique case (i_apb.paddr[11:0])
      `REG_CTRL, `REG_STATUS, `REG_EVT, `REG_WIN: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  // control and window writes; update-done is a self-clearing strobe
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_ff <= `CTRL_RESET;
      win_ff <= TW'(`TRIPLE_WIN_MS / `TICK_MS);
      upd_done_ff <= 1'b0;
    end else begin
      upd_done_ff <= 1'b0;
      if (wr_acc && i_apb.paddr[11:0] == `REG_CTRL) begin
        ctrl_ff <= {29'h0, i_apb.pwdata[2:0]};
        upd_done_ff <= i_apb.pwdata[`CTRL_UPD_DONE];
      end
      if (wr_acc && i_apb.paddr[11:0] == `REG_WIN) begin
        win_ff <= i_apb.pwdata[TW-1:0];
      end
    end
  end
  logic mot_dis, meas_dis, stor_dis;
  assign mot_dis = ctrl_ff[`CTRL_MOT_DIS];
  assign meas_dis = ctrl_ff[`CTRL_MEAS_DIS];
  assign stor_dis = ctrl_ff[`CTRL_STOR_DIS];

  // apb answer: registered, no wait states
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_apb <= '0;
    end else begin
      o_apb.pready <= i_apb.psel && !i_apb.penable;
      o_apb.pslverr <= i_apb.psel && !i_apb.penable && !addr_ok;
      if (rd_acc) begin
        unique case (i_apb.paddr[11:0])
          `REG_CTRL: o_apb.prdata <= ctrl_ff;
          `REG_STATUS: o_apb.prdata <= {24'h0, 3'h0, o_accel_en, o_update_active,
                                        mode_ff};
          `REG_EVT: o_apb.prdata <= {16'h0, btn_cnt_ff, mot_cnt_ff};
          `REG_WIN: o_apb.prdata <= {8'h0, win_ff};
          default: o_apb.prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // button hold and triple-press detection
  logic [TW-1:0] hold_ff, gap_ff;
  logic [1:0] press_ff;
  logic long_ff, triple, hold_hit;
  assign hold_hit = btn_s2_ff && tick && (hold_ff == HLD_PD);
  assign triple = btn_fall && !long_ff && (press_ff == 2'd2);
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_ff <= '0;
      long_ff <= 1'b0;
    end else if (!btn_s2_ff) begin
      hold_ff <= '0;
      long_ff <= 1'b0;
    end else if (tick && hold_ff <= HLD_PD) begin
      hold_ff <= hold_ff + 1'b1;
      long_ff <= long_ff | (hold_ff == HLD_PD);
    end
  end
  // presses counted on release, window from the first release
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      press_ff <= 2'd0;
      gap_ff <= '0;
    end else if (btn_fall) begin
      press_ff <= (long_ff || triple) ? 2'd0 : press_ff + 2'd1;
      if (press_ff == 2'd0) begin
        gap_ff <= '0;
      end
    end else if (press_ff != 2'd0 && tick) begin
      if (gap_ff + 1'b1 >= win_ff) begin
        press_ff <= 2'd0;
      end
      gap_ff <= gap_ff + 1'b1;
    end
  end

  // mode timers
  logic trig_entry, nom_t_hit, nom_d_hit, acc_hit, adv_hit, smp_hit, mot_seen;
  assign trig_entry = (nxt_mode == MODE_TRIGGERED) && (mode_ff != MODE_TRIGGERED);
  assign mot_seen = mot_rise && o_accel_en;
  tick_timer #(.W(TW)) u_nomot_trig (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_tick(tick),
    .i_clr(trig_entry || (mode_ff == MODE_TRIGGERED && mot_seen)),
    .i_run(mode_ff == MODE_TRIGGERED), .i_limit(NOM_T), .o_hit(nom_t_hit)
  );
  tick_timer #(.W(TW)) u_nomot_dflt (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_tick(tick), .i_clr(mot_seen),
    .i_run(mode_ff == MODE_DEFAULT && !stor_dis), .i_limit(NOM_D),
    .o_hit(nom_d_hit)
  );
  tick_timer #(.W(TW)) u_acc_restart (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_tick(tick), .i_clr(trig_entry),
    .i_run(mode_ff == MODE_TRIGGERED && !o_accel_en), .i_limit(ACC_R),
    .o_hit(acc_hit)
  );
  tick_timer #(.W(TW)) u_adv (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_tick(tick), .i_clr(nxt_mode != mode_ff),
    .i_run(mode_ff == MODE_TRIGGERED || mode_ff == MODE_DEFAULT),
    .i_limit(mode_ff == MODE_TRIGGERED ? ADV_T : ADV_D), .o_hit(adv_hit)
  );
  tick_timer #(.W(TW)) u_smp (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_tick(tick), .i_clr(nxt_mode != mode_ff),
    .i_run((mode_ff == MODE_TRIGGERED || mode_ff == MODE_DEFAULT) && !meas_dis),
    .i_limit(mode_ff == MODE_TRIGGERED ? SMP_T : SMP_D), .o_hit(smp_hit)
  );

  // mode transitions; power-down hold has top priority
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_DEFAULT: begin
        if (btn_rise || (mot_seen && !mot_dis)) nxt_mode = MODE_TRIGGERED;
        else if (nom_d_hit) nxt_mode = MODE_STORAGE;
      end
      MODE_TRIGGERED: begin
        if (nom_t_hit) nxt_mode = MODE_DEFAULT;
      end
      MODE_STORAGE, MODE_POWER_DOWN: nxt_mode = mode_ff; // leave only by reset
      MODE_UPDATE: nxt_mode = MODE_UPDATE;
      default: nxt_mode = MODE_DEFAULT;
    endcase
    if (triple && mode_ff inside {MODE_DEFAULT, MODE_TRIGGERED}) nxt_mode = MODE_UPDATE;
    if (hold_hit && mode_ff inside {MODE_DEFAULT, MODE_TRIGGERED}) begin
      nxt_mode = MODE_POWER_DOWN;
    end
  end
  // reset wakes into Triggered, as after a storage wake
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_ff <= MODE_TRIGGERED;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // accelerometer enable
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_accel_en <= 1'b0;
    end else if (trig_entry) begin
      o_accel_en <= 1'b0;
    end else if (acc_hit) begin
      o_accel_en <= !mot_dis;
    end else begin
      unique case (nxt_mode)
        MODE_DEFAULT, MODE_STORAGE: o_accel_en <= !mot_dis;
        MODE_POWER_DOWN, MODE_UPDATE: o_accel_en <= 1'b0;
        default: o_accel_en <= o_accel_en;
      endcase
    end
  end
  // wake request in low-power modes or on update done, a reset pulse
  logic [7:0] wake_ff;
  logic wake_req;
  assign wake_req = (mode_ff == MODE_STORAGE && (btn_rise || mot_rise)) ||
                    (mode_ff == MODE_POWER_DOWN && btn_rise) ||
                    (mode_ff == MODE_UPDATE && upd_done_ff);
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wake_ff <= 8'h00;
      o_sys_reset <= 1'b0;
    end else begin
      if (wake_req && wake_ff == 8'h00) wake_ff <= 8'(WAKE_CYC);
      else if (wake_ff != 8'h00) wake_ff <= wake_ff - 8'h01;
      o_sys_reset <= wake_req || wake_ff > 8'h01;
    end
  end
  // mode-dependent outputs
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_adv_pulse <= 1'b0;
      o_adv_en <= 1'b0;
      o_sample_pulse <= 1'b0;
      o_sensor_en <= 1'b0;
      o_cpu_off <= 1'b0;
      o_update_active <= 1'b0;
      o_mode <= MODE_TRIGGERED;
    end else begin
      o_adv_pulse <= adv_hit;
      o_adv_en <= nxt_mode inside {MODE_DEFAULT, MODE_TRIGGERED};
      o_sample_pulse <= smp_hit;
      o_sensor_en <= nxt_mode inside {MODE_DEFAULT, MODE_TRIGGERED} && !meas_dis;
      o_cpu_off <= nxt_mode inside {MODE_STORAGE, MODE_POWER_DOWN};
      o_update_active <= nxt_mode == MODE_UPDATE;
      o_mode <= nxt_mode;
    end
  end
  // event counters for status
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mot_cnt_ff <= 8'h00;
      btn_cnt_ff <= 8'h00;
    end else begin
      if (mot_seen) mot_cnt_ff <= mot_cnt_ff + 8'h01;
      if (btn_rise) btn_cnt_ff <= btn_cnt_ff + 8'h01;
    end
  end

  // checks
  property p_trig_accel_off;
    @(posedge i_mclk) disable iff (!i_rstn)
    trig_entry |=> !o_accel_en;
  endproperty
  a_trig_accel_off: assert property (p_trig_accel_off) else $error("accel on at trig entry");
  property p_pd_only_hold;
    @(posedge i_mclk) disable iff (!i_rstn)
    (mode_ff != MODE_POWER_DOWN) ##1 (mode_ff == MODE_POWER_DOWN) |-> $past(hold_hit);
  endproperty
  a_pd_only_hold: assert property (p_pd_only_hold) else $error("power down without hold");
  property p_pd_accel;
    @(posedge i_mclk) disable iff (!i_rstn)
    mode_ff == MODE_POWER_DOWN |=> !o_accel_en;
  endproperty
  a_pd_accel: assert property (p_pd_accel) else $error("accel on in power down");
  property p_stor_quiet;
    @(posedge i_mclk) disable iff (!i_rstn)
    mode_ff == MODE_STORAGE |=> !o_adv_en && !o_sensor_en && o_cpu_off;
  endproperty
  a_stor_quiet: assert property (p_stor_quiet) else $error("storage not quiet");
  property p_stor_dis;
    @(posedge i_mclk) disable iff (!i_rstn)
    stor_dis && mode_ff == MODE_DEFAULT |=> mode_ff != MODE_STORAGE;
  endproperty
  a_stor_dis: assert property (p_stor_dis) else $error("storage while disabled");
  property p_meas_off;
    @(posedge i_mclk) disable iff (!i_rstn)
    meas_dis |=> !o_sample_pulse;
  endproperty
  a_meas_off: assert property (p_meas_off) else $error("sampling while disabled");
  property p_wake;
    @(posedge i_mclk) disable iff (!i_rstn)
    mode_ff == MODE_STORAGE && mot_rise |=> o_sys_reset;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from storage");
  property p_mot_dis;
    @(posedge i_mclk) disable iff (!i_rstn)
    mode_ff == MODE_DEFAULT && mot_dis && !btn_rise ##1 mode_ff == MODE_TRIGGERED |-> 0;
  endproperty
  a_mot_dis: assert property (p_mot_dis) else $error("motion trigger while disabled");
  c_trig: cover property (@(posedge i_mclk) mode_ff == MODE_DEFAULT ##1 mode_ff == MODE_TRIGGERED);
  c_upd: cover property (@(posedge i_mclk) mode_ff == MODE_UPDATE);
  c_pd: cover property (@(posedge i_mclk) mode_ff == MODE_POWER_DOWN);
  c_stor: cover property (@(posedge i_mclk) mode_ff == MODE_DEFAULT ##1 mode_ff == MODE_STORAGE);
endmodule // tag_operation_mode_controller
`default_nettype wire

// file: src/tick_timer.sv
`timescale 1ns/1ps
`default_nettype none
// counts ticks while running, restarts on clr, pulses on reaching limit
module tick_timer #(
  parameter int W = 24
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_tick,
  input wire logic i_clr,
  input wire logic i_run,
  input wire logic [W-1:0] i_limit,
  output logic o_hit
);
  logic [W-1:0] cnt_ff;
  // clear wins over counting
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff <= '0;
    end else if (i_clr || !i_run) begin
      cnt_ff <= '0;
    end else if (i_tick) begin
      cnt_ff <= (cnt_ff + 1'b1 >= i_limit) ? '0 : cnt_ff + 1'b1;
    end
  end
  assign o_hit = i_run && !i_clr && i_tick && (cnt_ff + 1'b1 >= i_limit);
endmodule // tick_timer
`default_nettype wire

// file: verif/tag_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// pushbutton and accelerometer motion pin of the far side
module tag_far_side (
  input wire logic i_mclk,
  output logic o_button,
  output logic o_motion
);
  // both pins idle low at time zero
  initial begin
    o_button = 1'b0;
    o_motion = 1'b0;
  end
  // button held for len cycles, changed just after a rising edge
  task automatic press(input int len);
    @(posedge i_mclk);
    o_button <= 1'b1;
    repeat (len) @(posedge i_mclk);
    o_button <= 1'b0;
  endtask
  // short motion event, wide enough for the input synchroniser
  task automatic bump();
    @(posedge i_mclk);
    o_motion <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_motion <= 1'b0;
  endtask
endmodule // tag_far_side
`default_nettype wire

// file: verif/tag_operation_mode_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tag_mode_cfg.svh"
module tag_operation_mode_controller_tb import tag_mode_pkg::*;;
  logic i_mclk;
  logic i_rstn;
  logic button;
  logic motion;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic adv_pulse, adv_en, samp_pulse, sensor_en, accel_en, cpu_off, sys_reset, upd;
  op_mode_t mode;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int adv_last = 0, adv_gap = 0, samp_last = 0, samp_gap = 0, samp_n = 0;
  int t0;
  logic [31:0] rd;
  logic err;
  // 50 mhz clock
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // one tick per cycle and a short storage timeout keep the run short
  tag_operation_mode_controller #(.TICK_CYC(1), .NOMOT_DFLT_TK(2000)) dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_button(button), .i_motion(motion),
    .i_apb(apb_req), .o_apb(apb_rsp), .o_adv_pulse(adv_pulse), .o_adv_en(adv_en),
    .o_sample_pulse(samp_pulse), .o_sensor_en(sensor_en), .o_accel_en(accel_en),
    .o_cpu_off(cpu_off), .o_sys_reset(sys_reset), .o_update_active(upd), .o_mode(mode)
  );
  tag_far_side far (.i_mclk(i_mclk), .o_button(button), .o_motion(motion));
  // pulse spacing monitor
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (adv_pulse === 1'b1) begin
      adv_gap <= cyc - adv_last;
      adv_last <= cyc;
    end
    if (samp_pulse === 1'b1) begin
      samp_gap <= cyc - samp_last;
      samp_last <= cyc;
      samp_n <= samp_n + 1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_mode(input op_mode_t m);
    check({29'h0, mode}, {29'h0, m});
  endtask
  function automatic logic [31:0] near(input int v, input int e);
    return {31'h0, (v >= e - 24) && (v <= e + 24)};
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // apb transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    @(posedge i_mclk);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge i_mclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 16);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    if (n >= 16) check(32'h0, 32'h1);
  endtask
  task automatic do_reset();
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1'b1;
    t0 = cyc;
  endtask
  task automatic wait_mode(input op_mode_t m, input int lim);
    for (int n = 0; n < lim && mode !== m; n++) @(posedge i_mclk);
  endtask
  task automatic triple(input int gap);
    repeat (3) begin
      far.press(10);
      repeat (gap) @(posedge i_mclk);
    end
  endtask
  // hang guard
  initial begin
    repeat (95000) @(posedge i_mclk);
    error_cnt++;
    print_verdict();
  end
  // main sequence
  initial begin
    apb_req = '0;
    i_rstn = 1'b0;
    do_reset();
    chk_mode(MODE_TRIGGERED);
    apb(1'b0, `REG_WIN, 32'h0);
    check(rd, 32'h0000_03e8);
    apb(1'b0, `REG_CTRL, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b0, 32'h0000_0010, 32'h0);
    check({31'h0, err}, 32'h1);
    repeat (4200) @(posedge i_mclk);
    check(adv_gap, 32'd250);
    check(samp_gap, 32'd2000);
    check({31'h0, accel_en}, 32'h0);
    for (int n = 0; n < 12000 && accel_en !== 1'b1; n++) @(posedge i_mclk);
    check(near(cyc - t0, 15000), 32'h1);
    // motion restarts the no-motion count
    t0 = cyc;
    far.bump();
    wait_mode(MODE_DEFAULT, 25000);
    chk_mode(MODE_DEFAULT);
    check(near(cyc - t0, 20000), 32'h1);
    // motion and storage disabled: motion must not leave default, no storage
    apb(1'b1, `REG_CTRL, 32'h5);
    far.bump();
    repeat (20) @(posedge i_mclk);
    chk_mode(MODE_DEFAULT);
    repeat (20300) @(posedge i_mclk);
    check(adv_gap, 32'd10000);
    chk_mode(MODE_DEFAULT);
    far.press(20);
    repeat (10) @(posedge i_mclk);
    chk_mode(MODE_TRIGGERED);
    // measurement off: no sample pulses at all
    apb(1'b1, `REG_CTRL, 32'h2);
    t0 = samp_n;
    repeat (4500) @(posedge i_mclk);
    check(samp_n - t0, 32'd0);
    check({31'h0, sensor_en}, 32'h0);
    apb(1'b1, `REG_CTRL, 32'h0);
    // hold below and above the power-down threshold
    far.press(1500);
    repeat (10) @(posedge i_mclk);
    chk_mode(MODE_TRIGGERED);
    repeat (1200) @(posedge i_mclk);
    far.press(2600);
    repeat (10) @(posedge i_mclk);
    chk_mode(MODE_POWER_DOWN);
    check({29'h0, cpu_off, accel_en, adv_en}, 32'h4);
    far.bump();
    repeat (30) @(posedge i_mclk);
    check({31'h0, sys_reset}, 32'h0);
    far.press(4);
    for (int n = 0; n < 60 && sys_reset !== 1'b1; n++) @(posedge i_mclk);
    check({31'h0, sys_reset}, 32'h1);
    do_reset();
    chk_mode(MODE_TRIGGERED);
    // narrow press window: slow presses must not count
    apb(1'b1, `REG_WIN, 32'd60);
    triple(100);
    chk_mode(MODE_TRIGGERED);
    repeat (100) @(posedge i_mclk);
    triple(10);
    chk_mode(MODE_UPDATE);
    check({31'h0, upd}, 32'h1);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd, 32'h0000_000c);
    apb(1'b1, `REG_CTRL, 32'h8);
    for (int n = 0; n < 40 && sys_reset !== 1'b1; n++) @(posedge i_mclk);
    check({31'h0, sys_reset}, 32'h1);
    // storage after the default no-motion time, motion wakes it
    do_reset();
    wait_mode(MODE_DEFAULT, 21000);
    chk_mode(MODE_DEFAULT);
    t0 = cyc;
    wait_mode(MODE_STORAGE, 2100);
    chk_mode(MODE_STORAGE);
    check(near(cyc - t0, 2000), 32'h1);
    check({29'h0, accel_en, adv_en, sensor_en}, 32'h4);
    check({31'h0, cpu_off}, 32'h1);
    far.bump();
    for (int n = 0; n < 40 && sys_reset !== 1'b1; n++) @(posedge i_mclk);
    check({31'h0, sys_reset}, 32'h1);
    do_reset();
    chk_mode(MODE_TRIGGERED);
    print_verdict();
  end
endmodule // tag_operation_mode_controller_tb
`default_nettype wire
